/* design/fes_pkg.sv */
package fes_pkg;

  // ==========================================================
  // Flash bus widths and command codes
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_SETUP    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;

  // ==========================================================
  // Status bit positions
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_WINDOW  = 3;
  localparam int BIT_SUSTOG  = 2;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int WINDOW_US      = 50;
  localparam int WINDOW_CYC     = WINDOW_US * CLK_MHZ;
  localparam int SUSPEND_MAX_US = 20;
  localparam int SUSPEND_CYC    = SUSPEND_MAX_US * CLK_MHZ;
  localparam int WR_PULSE_CYC   = 4;
  localparam int RESET_CYC      = 50;
  localparam logic [3:0] WE_CNT_RST = 4'h0;

  // ==========================================================
  // APB register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SECTOR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FSTAT  = 8'h0C;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO     = 4;
  localparam int CTRL_HWRST  = 5;

  typedef enum logic [2:0] {
    FES_OP_CHIP, FES_OP_SECTOR, FES_OP_ADD, FES_OP_SUSPEND,
    FES_OP_RESUME, FES_OP_RESET, FES_OP_POLL
  } fes_op_e;

  // Flash pin bundle driven by the controller
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              reset_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } fes_pins_s;

  // One bus cycle request to the pin engine
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fes_cyc_s;

endpackage : fes_pkg

/* design/fes_bus_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
module fes_bus_cycle (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  // Cycle request
  input  wire logic               i_start,
  input  wire fes_pkg::fes_cyc_s  i_cyc,
  output logic                    o_done,
  output logic [7:0]              o_rdata,
  // Pins
  input  wire logic [7:0]         i_dq_sync,
  output var fes_pkg::fes_pins_s  o_pins
);
  import fes_pkg::*;

  logic [3:0] cnt;
  logic       busy;

  // ==========================================================
  // Strobe timing: low for WR_PULSE_CYC + 2 cycles, then release
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy    <= 1'b0;
      cnt     <= WE_CNT_RST;
      o_done  <= 1'b0;
      o_rdata <= 8'h00;
      o_pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1,
                   addr: '0, dq_out: '0, dq_oe_n: 1'b1};
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!busy && i_start) begin
        busy           <= 1'b1;
        cnt            <= WE_CNT_RST;
        o_pins.addr    <= i_cyc.addr;
        o_pins.dq_out  <= {8'h00, i_cyc.data};  // [R26]
        o_pins.dq_oe_n <= !i_cyc.write;
        o_pins.ce_n    <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h0) begin
          o_pins.we_n <= !i_cyc.write;
          o_pins.oe_n <= i_cyc.write;
        end else if (cnt == 4'(WR_PULSE_CYC + 2)) begin
          // Read data lags two sync stages
          o_rdata        <= i_dq_sync;
          o_pins.we_n    <= 1'b1;
          o_pins.oe_n    <= 1'b1;
        end else if (cnt == 4'(WR_PULSE_CYC + 3)) begin
          o_pins.ce_n    <= 1'b1;
          o_pins.dq_oe_n <= 1'b1;
          busy           <= 1'b0;
          o_done         <= 1'b1;
        end
      end
    end
  end

endmodule : fes_bus_cycle
`default_nettype wire

/* design/fes_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Chip erase is six writes: two unlocks, setup, two unlocks, chip command.
// R2: Device preprograms itself; controller supplies nothing extra during erase.
// R3: Device ignores commands during chip erase; controller still sends any command launched while not busy.
// R4: Hardware reset aborts chip erase; reissue full sequence afterwards.
// R5: Progress shows in polling, toggle, suspend toggle bits and ready/busy.
// R6: After erase the device returns to array read.
// R7: Sector erase is six writes, last carries sector address and command.
// R8: Acceptance window of 50 us starts at last write strobe rise.
// R9: Extra sector writes within 50 us of the previous are queued.
// R10: Controller sends each extra sector as a single-write add command launched by the host.
// R11: Other command inside window aborts; whole sequence must be rewritten.
// R12: Erase window flag shows window expiry; polling optional if fast.
// R13: After erasing starts only suspend is accepted.
// R14: Hardware reset aborts sector erase; reissue sequence afterwards.
// R15: Suspend honoured only during sector erase, including its window.
// R16: Suspend in window ends window at once; address is don't care.
// R17: Suspend during active erase takes effect within 20 us.
// R18: Suspended sectors read status; other sectors read normally.
// R19: Polling or toggle plus suspend toggle tell erasing from suspended.
// R20: Program during suspend reports status normally.
// R21: Autoselect allowed during suspend, exit returns to suspend.
// R22: Resume continues erase; extra resumes ignored; suspend again allowed.
// R23: Reset command between sequence cycles abandons the sequence.
// R24: Timeout bit high during erase needs reset command.
// R25: Sector is chosen by upper address bits only.
// R26: Upper data byte ignored on command writes.
// R27: Strobes are synchronised and edge detected by a clocked device.
module fes_ctrl #(
  parameter int WINDOW_CYCLES  = fes_pkg::WINDOW_CYC,
  parameter int SUSPEND_CYCLES = fes_pkg::SUSPEND_CYC
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [7:0]              i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  output logic [31:0]                  o_prdata,
  // Flash pins
  input  wire logic [7:0]              i_dq,
  input  wire logic                    i_ready_busy,
  output var fes_pkg::fes_pins_s       o_pins
);
  import fes_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT, ST_HWRST
  } fes_state_e;

  initial begin
    if (WINDOW_CYCLES < 1 || SUSPEND_CYCLES < 1)
      $error("cycle counts must be positive");
  end

  fes_state_e  state;
  fes_op_e     op;
  logic [2:0]  step;
  logic [2:0]  last_step;
  logic [7:0]  sector;
  logic [31:0] gap_cnt;
  logic        busy;
  logic        erasing;
  logic        suspended;
  logic        window_open;
  logic        timeout_seen;
  logic        chip_erase;
  logic        cyc_start;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic [7:0]  last_status;
  logic [7:0]  prev_status;
  logic [7:0]  dq_meta;
  logic [7:0]  dq_sync;
  logic [1:0]  rb_meta;
  logic        rb_sync;
  fes_cyc_s    cyc;
  fes_pins_s   eng_pins;
  logic [15:0] rst_cnt;
  logic        hw_reset_n;

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
      rb_meta <= 2'h0;
      rb_sync <= 1'b0;
    end else if (i_ce) begin
      dq_meta <= i_dq;
      dq_sync <= dq_meta;
      rb_meta <= {rb_meta[0], i_ready_busy};
      rb_sync <= rb_meta[1];
    end
  end

  // ==========================================================
  // Command cycle table
  always_comb begin
    cyc = '{write: 1'b1, addr: '0, data: 8'h00};
    last_step = 3'd5;
    unique case (op)
      FES_OP_CHIP, FES_OP_SECTOR: begin
        unique case (step)
          3'd0, 3'd3: cyc = '{1'b1, 20'(UNLOCK_ADDR1), UNLOCK_DATA1};
          3'd1, 3'd4: cyc = '{1'b1, 20'(UNLOCK_ADDR2), UNLOCK_DATA2};
          3'd2:       cyc = '{1'b1, 20'(UNLOCK_ADDR1), CMD_SETUP};
          default: begin
            if (op == FES_OP_CHIP)
              cyc = '{1'b1, 20'(UNLOCK_ADDR1), CMD_CHIP};  // [R1]
            else
              cyc = '{1'b1, {sector, 12'h000}, CMD_SECTOR};  // [R7] [R25]
          end
        endcase
      end
      FES_OP_ADD: begin
        last_step = 3'd0;
        cyc = '{1'b1, {sector, 12'h000}, CMD_SECTOR};  // [R9] [R25]
      end
      FES_OP_SUSPEND: begin
        last_step = 3'd0;
        cyc = '{1'b1, 20'h00000, CMD_SUSPEND};  // [R16]
      end
      FES_OP_RESUME: begin
        last_step = 3'd0;
        cyc = '{1'b1, 20'h00000, CMD_RESUME};  // [R22]
      end
      FES_OP_RESET: begin
        last_step = 3'd0;
        cyc = '{1'b1, 20'h00000, CMD_RESET};  // [R23] [R24]
      end
      FES_OP_POLL: begin
        last_step = 3'd1;
        cyc = '{1'b0, {sector, 12'h000}, 8'h00};  // [R18]
      end
    endcase
  end

  assign cyc_start = (state == ST_ISSUE);

  fes_bus_cycle u_cycle (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_start   (cyc_start),
    .i_cyc     (cyc),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .i_dq_sync (dq_sync),
    .o_pins    (eng_pins)
  );

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      step  <= 3'd0;
    end else if (i_ce) begin
      unique case (state)
        ST_IDLE: begin
          step <= 3'd0;
          if (busy)
            state <= ST_ISSUE;
        end
        ST_ISSUE: state <= ST_WAIT;
        ST_WAIT: begin
          if (cyc_done) begin
            if (step == last_step) begin
              state <= ST_IDLE;
            end else begin
              step  <= step + 3'd1;
              state <= ST_ISSUE;  // [R10]
            end
          end
        end
        ST_HWRST: begin
          if (rst_cnt == 16'(RESET_CYC))
            state <= ST_IDLE;
        end
      endcase
      if (busy && op == FES_OP_RESET && state == ST_IDLE && rst_cnt == 16'h0
          && hw_reset_n == 1'b0)
        state <= ST_HWRST;
    end
  end

  // ==========================================================
  // Hardware reset pulse
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt    <= 16'h0;
      hw_reset_n <= 1'b1;
    end else if (i_ce) begin
      if (state == ST_HWRST) begin
        rst_cnt    <= rst_cnt + 16'h1;
        hw_reset_n <= (rst_cnt == 16'(RESET_CYC));  // [R4] [R14]
      end else if (i_psel && i_penable && i_pwrite && i_paddr == REG_CTRL
                   && i_pwdata[CTRL_HWRST] && !busy) begin
        rst_cnt    <= 16'h0;
        hw_reset_n <= 1'b0;
      end else begin
        rst_cnt    <= 16'h0;
      end
    end
  end

  // ==========================================================
  // APB registers and erase tracking
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pready     <= 1'b0;
      o_pslverr    <= 1'b0;
      o_prdata     <= 32'h0;
      op           <= FES_OP_RESET;
      busy         <= 1'b0;
      sector       <= 8'h00;
      erasing      <= 1'b0;
      suspended    <= 1'b0;
      window_open  <= 1'b0;
      timeout_seen <= 1'b0;
      chip_erase   <= 1'b0;
      gap_cnt      <= 32'h0;
      last_status  <= 8'h00;
      prev_status  <= 8'h00;
    end else if (i_ce) begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          REG_CTRL:   o_prdata <= {27'h0, busy, 1'b0, 3'(op)};
          REG_SECTOR: o_prdata <= {24'h0, sector};
          REG_STATUS: o_prdata <= {26'h0, timeout_seen, window_open,
                                   suspended, erasing, busy, rb_sync};
          REG_FSTAT:  o_prdata <= {16'h0, prev_status, last_status};
          default: begin
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b1;
          end
        endcase
      end
      // Command launch; refused while busy
      if (i_psel && i_penable && o_pready && i_pwrite && !busy) begin
        if (i_paddr == REG_SECTOR)
          sector <= i_pwdata[7:0];
        // Undefined op code refused
        if (i_paddr == REG_CTRL && i_pwdata[CTRL_GO]
            && i_pwdata[CTRL_OP_LSB +: 3] != 3'h7) begin
          op   <= fes_op_e'(i_pwdata[CTRL_OP_LSB +: 3]);
          busy <= 1'b1;
        end
        if (i_paddr == REG_CTRL && i_pwdata[CTRL_HWRST]) begin
          op   <= FES_OP_RESET;
          busy <= 1'b1;
        end
      end
      // Window timer from last strobe rise
      if (window_open && gap_cnt < 32'(WINDOW_CYCLES))
        gap_cnt <= gap_cnt + 32'h1;  // [R8] [R27]
      else if (window_open)
        window_open <= 1'b0;  // [R12]
      if (state == ST_WAIT && cyc_done && step == last_step) begin
        busy <= 1'b0;
        unique case (op)
          FES_OP_CHIP: begin
            erasing    <= 1'b1;  // [R2] [R3]
            chip_erase <= 1'b1;
          end
          FES_OP_SECTOR, FES_OP_ADD: begin
            erasing     <= 1'b1;
            chip_erase  <= 1'b0;
            window_open <= 1'b1;
            gap_cnt     <= 32'h0;
          end
          FES_OP_SUSPEND: begin
            suspended   <= erasing && !chip_erase;  // [R15] [R17]
            window_open <= 1'b0;  // [R16]
          end
          FES_OP_RESUME: suspended <= 1'b0;  // [R22]
          FES_OP_RESET: begin
            window_open  <= 1'b0;  // [R11] [R23]
            timeout_seen <= 1'b0;
            if (!hw_reset_n || timeout_seen || window_open)
              erasing <= 1'b0;
          end
          FES_OP_POLL: begin
            prev_status <= last_status;
            last_status <= cyc_rdata;
            // Toggle stuck and ready means done
            // Suspended erase also reads ready with a still toggle bit
            if (rb_sync && !suspended
                && cyc_rdata[BIT_TOGGLE] == last_status[BIT_TOGGLE])
              erasing <= 1'b0;  // [R5] [R6] [R19]
            if (cyc_rdata[BIT_TIMEOUT])
              timeout_seen <= 1'b1;  // [R24]
          end
          default: ;
        endcase
      end
      if (state == ST_HWRST && rst_cnt == 16'(RESET_CYC)) begin
        busy      <= 1'b0;
        erasing   <= 1'b0;  // [R4] [R14]
        suspended <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pin output
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      o_pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1,
                  addr: '0, dq_out: '0, dq_oe_n: 1'b1};
    else if (i_ce) begin
      o_pins         <= eng_pins;
      o_pins.reset_n <= hw_reset_n;
    end
  end

endmodule : fes_ctrl
`default_nettype wire

/* verif/fes_ctrl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module fes_ctrl_props
  import fes_pkg::*;
#(
  parameter int WINDOW_CYCLES  = WINDOW_CYC,
  parameter int SUSPEND_CYCLES = SUSPEND_CYC
) (
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic              i_ce,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [7:0]        i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic [31:0]       o_prdata,
  input wire logic [7:0]        i_dq,
  input wire logic              i_ready_busy,
  input wire fes_pkg::fes_pins_s o_pins
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic mapped;
  assign mapped = i_paddr inside {REG_CTRL, REG_SECTOR, REG_STATUS, REG_FSTAT};

  // ==========================================================
  // Bus handshake
  property p_ready_after_setup;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_in_access;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("pready outside access phase");
  property p_err_unmapped;
    o_pready && !mapped |-> o_pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("no error on unmapped address");
  property p_err_mapped;
    o_pready && mapped |-> !o_pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped)
    else $error("error on mapped address");

  // ==========================================================
  // Flash write cycles and read contention
  sequence s_strobe_low;
    !o_pins.we_n [*3];
  endsequence
  sequence s_select_ends;
    ##[1:2] o_pins.ce_n;
  endsequence
  property p_we_select;
    !o_pins.we_n |-> !o_pins.ce_n && o_pins.oe_n;
  endproperty
  a_we_select: assert property (p_we_select)
    else $error("write strobe without select");
  property p_drive_low_byte;
    !o_pins.we_n |-> !o_pins.dq_oe_n && o_pins.dq_out[15:8] == 8'h00;
  endproperty
  a_drive_low_byte: assert property (p_drive_low_byte)
    else $error("data not driven during write");
  property p_hold;
    !o_pins.we_n && !$past(o_pins.we_n)
      |-> $stable(o_pins.addr) && $stable(o_pins.dq_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved in write");
  property p_we_pulse;
    $fell(o_pins.we_n) |-> s_strobe_low ##[1:6] o_pins.we_n ##0 s_select_ends;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse malformed");
  property p_no_contention;
    !o_pins.oe_n |-> o_pins.dq_oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("data driven while reading");
endmodule : fes_ctrl_props

bind fes_ctrl fes_ctrl_props #(
  .WINDOW_CYCLES(WINDOW_CYCLES), .SUSPEND_CYCLES(SUSPEND_CYCLES)
) i_fes_ctrl_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_prdata(o_prdata), .i_dq(i_dq), .i_ready_busy(i_ready_busy),
  .o_pins(o_pins)
);
`default_nettype wire

/* verif/fes_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fes_flash_model
  import fes_pkg::*;
#(
  parameter int ERASE_CYC = 400,
  parameter int WIN_CYC   = 1500
) (
  input  wire logic              i_clock,
  input  wire fes_pkg::fes_pins_s i_pins,
  output logic [7:0]             o_dq,
  output logic                   o_ready_busy
);
  // States: 0 array read, 1 window, 2 erasing, 3 suspended
  logic [1:0]  st = 2'd0;
  logic        chip = 1'b0;
  logic        tog = 1'b0;
  logic        stog = 1'b0;
  logic [7:0]  last = 8'h00;
  logic [7:0]  sa = 8'h00;
  logic [7:0]  d;
  logic [10:0] ua;
  int          step = 0;
  int          timer = 0;
  int          nwr = 0;
  int          nsect = 0;

  // ==========================================================
  // Command decoder
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && i_pins.reset_n) begin
      d = i_pins.dq_out[7:0];
      ua = i_pins.addr[10:0];
      nwr++;
      case (st)
        2'd0: begin
          if (d == CMD_RESET) step = 0;
          else if ((step == 0 || step == 3) && ua == UNLOCK_ADDR1
                   && d == UNLOCK_DATA1) step++;
          else if ((step == 1 || step == 4) && ua == UNLOCK_ADDR2
                   && d == UNLOCK_DATA2) step++;
          else if (step == 2 && ua == UNLOCK_ADDR1 && d == CMD_SETUP) step++;
          else if (step == 5 && ua == UNLOCK_ADDR1 && d == CMD_CHIP) begin
            st = 2'd2;
            chip = 1'b1;
            timer = ERASE_CYC;
            step = 0;
          end else if (step == 5 && d == CMD_SECTOR) begin
            st = 2'd1;
            chip = 1'b0;
            nsect = 1;
            sa = i_pins.addr[19:12];
            timer = WIN_CYC;
            step = 0;
          end else step = 0;
        end
        2'd1: begin
          if (d == CMD_SECTOR) begin
            nsect++;
            sa = i_pins.addr[19:12];
            timer = WIN_CYC;
          end else if (d == CMD_SUSPEND) begin
            st = 2'd3;
            timer = ERASE_CYC;
          end else st = 2'd0;
        end
        2'd2: if (!chip && d == CMD_SUSPEND) st = 2'd3;
        default: if (d == CMD_RESUME) st = 2'd2;
      endcase
    end
  end

  // Embedded timers run without host help
  always @(posedge i_clock) begin
    if ((st == 2'd1 || st == 2'd2) && timer > 0) begin
      timer--;
      if (timer == 0 && st == 2'd1) begin
        st = 2'd2;
        timer = ERASE_CYC;
      end else if (timer == 0) st = 2'd0;
    end
  end

  always @(negedge i_pins.reset_n) begin
    st = 2'd0;
    step = 0;
  end

  // ==========================================================
  // Status reads
  always @(negedge i_pins.oe_n) begin
    if (st == 2'd1 || st == 2'd2) tog = ~tog;
    if (st != 2'd0) stog = ~stog;
  end
  assign o_ready_busy = (st == 2'd0 || st == 2'd3);
  assign o_dq = (i_pins.ce_n || i_pins.oe_n) ? ~last
              : (st == 2'd0) ? 8'hFF
              : {st == 2'd3, tog, 2'b00, st != 2'd1, stog, 2'b00};
  always @(negedge i_clock) if (!i_pins.oe_n) last = o_dq;
endmodule : fes_flash_model
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fes_pkg::*;
  localparam int          WIN = 1500;
  localparam logic [31:0] GO  = 32'h0000_0010;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [7:0]  dq;
  logic        rb;
  fes_pins_s   pins;
  int          err_count = 0;
  int          samples_checked = 0;
  int          n0;

  always #5 clk = ~clk;

  fes_ctrl #(.WINDOW_CYCLES(WIN), .SUSPEND_CYCLES(SUSPEND_CYC)) i_fes_ctrl (
    .i_clock(clk), .i_rst(rst), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_dq(dq), .i_ready_busy(rb), .o_pins(pins));
  fes_flash_model #(.ERASE_CYC(400), .WIN_CYC(WIN)) i_fes_flash_model (
    .i_clock(clk), .i_pins(pins), .o_dq(dq), .o_ready_busy(rb));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic run_op(input logic [31:0] cw, input logic [7:0] sect);
    apb(1'b1, REG_SECTOR, {24'h0, sect});
    apb(1'b1, REG_CTRL, cw);
    do apb(1'b0, REG_STATUS, 32'h0); while (rd[1] !== 1'b0);
  endtask : run_op

  task automatic poll_done;
    while (i_fes_flash_model.st !== 2'd0) run_op(GO | FES_OP_POLL, 8'h00);
    run_op(GO | FES_OP_POLL, 8'h00);
    run_op(GO | FES_OP_POLL, 8'h00);
    apb(1'b0, REG_FSTAT, 32'h0);
    chk("array_byte", 32'hFF, {24'h0, rd[7:0]});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("erasing_flag", 32'h0, {31'h0, rd[2]});
  endtask : poll_done

  task automatic chk_st(input string nm, input logic [1:0] e);
    chk(nm, {30'h0, e}, {30'h0, i_fes_flash_model.st});
  endtask : chk_st

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_reset", 32'(FES_OP_RESET), rd);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_reset", 32'h1, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    n0 = i_fes_flash_model.nwr;
    run_op(GO | FES_OP_CHIP, 8'h00);
    chk("chip_writes", 32'd6, 32'(i_fes_flash_model.nwr - n0));
    chk_st("chip_erasing", 2'd2);
    run_op(GO | FES_OP_SUSPEND, 8'h00);
    chk_st("chip_no_suspend", 2'd2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("chip_susp_flag", 32'h0, {31'h0, rd[3]});
    poll_done();
    run_op(GO | FES_OP_CHIP, 8'h00);
    run_op(32'h20, 8'h00);
    chk_st("hw_reset_abort", 2'd0);
    n0 = i_fes_flash_model.nwr;
    run_op(GO | FES_OP_SECTOR, 8'h3C);
    chk("sector_writes", 32'd6, 32'(i_fes_flash_model.nwr - n0));
    chk("sector_addr", 32'h3C, {24'h0, i_fes_flash_model.sa});
    chk_st("window_open", 2'd1);
    run_op(GO | FES_OP_ADD, 8'hC3);
    chk("queued", 32'd2, 32'(i_fes_flash_model.nsect));
    chk("added_addr", 32'hC3, {24'h0, i_fes_flash_model.sa});
    run_op(GO | FES_OP_SUSPEND, 8'h00);
    chk_st("window_suspend", 2'd3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("window_susp_flags", 32'h08, rd & 32'h18);
    run_op(GO | FES_OP_POLL, 8'h00);
    apb(1'b0, REG_FSTAT, 32'h0);
    chk("suspended_bits", 32'h88, rd & 32'h88);
    run_op(GO | FES_OP_RESUME, 8'h00);
    chk_st("resumed", 2'd2);
    run_op(GO | FES_OP_POLL, 8'h00);
    apb(1'b0, REG_FSTAT, 32'h0);
    chk("erasing_bits", 32'h08, rd & 32'h88);
    run_op(GO | FES_OP_SUSPEND, 8'h00);
    chk_st("resuspend", 2'd3);
    run_op(GO | FES_OP_RESUME, 8'h00);
    poll_done();
    run_op(GO | FES_OP_SECTOR, 8'h01);
    run_op(GO | FES_OP_RESET, 8'h00);
    chk_st("window_abort", 2'd0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("abort_flags", 32'h0, rd & 32'h14);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
